// File: dlp_pkg.sv
//==========================================================================
// Purpose: Shared constants, types and lane packing for the dual-channel
//          pixel link between a video source and a 1920x1080 panel.
// Assumes: Lanes are shown deserialized, one 7-bit word per link clock.
// Notes:   Odd channel carries pixels 1,3,5..; even carries 2,4,6..
//
// Operation
// - Active image 1920 pixels by 1080 lines
// - First channel odd pixels, second even
// - Source latches parallel pixels on falling edge
// - Odd and even clocks share identical timing
// - Colours 8 bits, bit 7 most significant
// - Display flag rides odd channel lane 2
// - Four data lanes plus clock per channel
// - Supply off: all link lines held low
// - Clock spread within plus or minus 3%
// - Spread modulation at most 200 kHz
// - Line and frame position from flag only
//==========================================================================
package dlp_pkg;

   //=======================================================================
   // Geometry and timing
   localparam int H_ACTIVE_PX  = 1920;
   localparam int V_ACTIVE     = 1080;
   localparam int PAIRS        = H_ACTIVE_PX / 2;
   localparam int H_BLANK_TYP  = 100;
   localparam int H_BLANK_MAX  = 1087;
   localparam int V_BLANK_TYP  = 40;
   localparam int CNT_W        = 11;
   localparam int CLK_MHZ      = 125;
   localparam int LINK_DIV     = 2;
   localparam int LINK_MHZ     = CLK_MHZ / LINK_DIV;
   localparam int SPREAD_PCT   = 3;
   localparam int SPREAD_KHZ   = 200;
   localparam int FIFO_DEPTH   = 8;

   //=======================================================================
   // Lane layout
   localparam int COL_W    = 8;
   localparam int LANE_W   = 7;
   localparam int LANES    = 4;
   localparam int LO_BITS  = 6;
   localparam int B_SPLIT  = 2;
   localparam int G_SPLIT  = 1;
   localparam int FLAG_BIT = 3 * LANE_W - 1;

   typedef struct packed {
      logic [COL_W-1:0] r;
      logic [COL_W-1:0] g;
      logic [COL_W-1:0] b;
   } dlp_rgb_t;

   typedef logic [LANES*LANE_W-1:0] dlp_word_t;

   // Lane 3 | lane 2 | lane 1 | lane 0; sync slots on lane 2 stay zero
   function automatic dlp_word_t dlp_pack(dlp_rgb_t p, logic flag);
      return {1'h0, p.b[COL_W-1:LO_BITS], p.g[COL_W-1:LO_BITS],
              p.r[COL_W-1:LO_BITS],
              flag, 2'h0, p.b[LO_BITS-1:B_SPLIT],
              p.b[B_SPLIT-1:0], p.g[LO_BITS-1:G_SPLIT],
              p.g[G_SPLIT-1:0], p.r[LO_BITS-1:0]};
   endfunction : dlp_pack

   function automatic dlp_rgb_t dlp_unpack(dlp_word_t w);
      dlp_rgb_t p;
      {p.b[COL_W-1:LO_BITS], p.g[COL_W-1:LO_BITS], p.r[COL_W-1:LO_BITS],
       p.b[LO_BITS-1:B_SPLIT], p.b[B_SPLIT-1:0], p.g[LO_BITS-1:G_SPLIT],
       p.g[G_SPLIT-1:0], p.r[LO_BITS-1:0]} =
         {w[LANES*LANE_W-2:FLAG_BIT+1], w[FLAG_BIT-3:0]};
      return p;
   endfunction : dlp_unpack

endpackage : dlp_pkg

// File: dlp_link_if.sv
//==========================================================================
// Purpose: The two pixel channels as seen between source and panel.
// Assumes: Each lane word is the deserialized 7 bits of one link clock.
// Notes:   No clocking block; both clocks are driven by the source.
//==========================================================================
interface dlp_link_if;
   import dlp_pkg::*;

   logic [LANE_W-1:0] odd_lane_0;
   logic [LANE_W-1:0] odd_lane_1;
   logic [LANE_W-1:0] odd_lane_2;
   logic [LANE_W-1:0] odd_lane_3;
   logic [LANE_W-1:0] even_lane_0;
   logic [LANE_W-1:0] even_lane_1;
   logic [LANE_W-1:0] even_lane_2;
   logic [LANE_W-1:0] even_lane_3;
   logic              odd_lane_clock;
   logic              even_lane_clock;

   modport src (
      output odd_lane_0, odd_lane_1, odd_lane_2, odd_lane_3,
      output even_lane_0, even_lane_1, even_lane_2, even_lane_3,
      output odd_lane_clock, even_lane_clock
   );

   modport sink (
      input odd_lane_0, odd_lane_1, odd_lane_2, odd_lane_3,
      input even_lane_0, even_lane_1, even_lane_2, even_lane_3,
      input odd_lane_clock, even_lane_clock
   );
endinterface : dlp_link_if

// File: dlp_fifo.sv
//==========================================================================
// Purpose: Small synchronous FIFO for pixel pairs ahead of the link.
// Assumes: One clock; push and pop may occur in the same cycle.
// Notes:   in_ready_o and out_valid_o are registered flags.
//==========================================================================
module dlp_fifo
   import dlp_pkg::*;
#(
   parameter int W     = 48,
   parameter int DEPTH = FIFO_DEPTH
) (
   input  wire logic         clk_i,
   input  wire logic         rst_n_i,
   input  wire logic         in_valid_i,
   input  wire logic [W-1:0] in_data_i,
   output logic              in_ready_o,
   output logic              out_valid_o,
   output logic [W-1:0]      out_data_o,
   input  wire logic         out_ready_i
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   typedef struct packed {
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [CW-1:0] cnt;
      logic          ready;
      logic          valid;
   } dlp_fifo_st_t;

   dlp_fifo_st_t   s_reg;
   dlp_fifo_st_t   s_next;
   logic [W-1:0]   mem [DEPTH];
   logic           push;
   logic           pop;

   assign push        = in_valid_i && s_reg.ready;
   assign pop         = out_ready_i && s_reg.valid;
   assign in_ready_o  = s_reg.ready;
   assign out_valid_o = s_reg.valid;
   assign out_data_o  = mem[s_reg.rd];

   //=======================================================================
   // Pointer and flag update
   always_comb begin
      s_next = s_reg;
      if (push) begin
         s_next.wr = (int'(s_reg.wr) == DEPTH - 1) ? '0 : s_reg.wr + 1'b1;
      end
      if (pop) begin
         s_next.rd = (int'(s_reg.rd) == DEPTH - 1) ? '0 : s_reg.rd + 1'b1;
      end
      s_next.cnt   = s_reg.cnt + CW'(push) - CW'(pop);
      s_next.ready = int'(s_next.cnt) != DEPTH;
      s_next.valid = s_next.cnt != '0;
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_reg <= '{wr: '0, rd: '0, cnt: '0, ready: 1'b1, valid: 1'b0};
      end else begin
         s_reg <= s_next;
      end
   end

   // Storage needs no reset; valid guards every read
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[s_reg.wr] <= in_data_i;
      end
   end
endmodule : dlp_fifo

// File: dlp_src.sv
//==========================================================================
// Purpose: Video source end: paces pixel pairs from a FIFO onto the two
//          channels with the display flag and a divided link clock.
// Assumes: panel_on_i is asynchronous; clk_i runs at CLK_MHZ.
// Notes:   Link clock is clk_i divided by two, no spreading applied.
//==========================================================================
module dlp_src
   import dlp_pkg::*;
#(
   parameter int H_BLANK = H_BLANK_TYP,
   parameter int V_BLANK = V_BLANK_TYP
) (
   input  wire logic     clk_i,
   input  wire logic     rst_n_i,
   input  wire logic     panel_on_i,
   input  wire logic     pix_valid_i,
   input  wire dlp_rgb_t pix_odd_i,
   input  wire dlp_rgb_t pix_even_i,
   output logic          pix_ready_o,
   output logic          underrun_o,
   output logic          frame_done_o,
   dlp_link_if.src       link
);
   localparam int H_TOTAL = PAIRS + H_BLANK;
   localparam int V_TOTAL = V_ACTIVE + V_BLANK;

   typedef enum logic {
      S_OFF,
      S_RUN
   } dlp_src_state_t;

   typedef struct packed {
      logic           on_meta;
      logic           on_sync;
      dlp_src_state_t st;
      logic           clk_odd;
      logic           clk_even;
      logic [CNT_W-1:0] h_cnt;
      logic [CNT_W-1:0] v_cnt;
      dlp_word_t      odd_word;
      dlp_word_t      even_word;
      logic           underrun;
      logic           frame_done;
   } dlp_src_st_t;

   dlp_src_st_t s_reg;
   dlp_src_st_t s_next;

   logic          fifo_valid;
   logic [47:0]   fifo_data;
   logic          launch;
   logic          active;
   logic          pop;
   dlp_rgb_t      odd_px;
   dlp_rgb_t      even_px;

   //=======================================================================
   // Pixel pair buffer
   dlp_fifo #(
      .W     (2 * $bits(dlp_rgb_t)),
      .DEPTH (FIFO_DEPTH)
   ) dlp_fifo_i (
      .clk_i       (clk_i),
      .rst_n_i     (rst_n_i),
      .in_valid_i  (pix_valid_i),
      .in_data_i   ({pix_odd_i, pix_even_i}),
      .in_ready_o  (pix_ready_o),
      .out_valid_o (fifo_valid),
      .out_data_o  (fifo_data),
      .out_ready_i (pop)
   );

   assign {odd_px, even_px} = fifo_data;

   //=======================================================================
   // Launch point and window
   // Words change only when the link clock falls, so the panel sees them
   // settled for half a period before its rising sample
   assign launch = (s_reg.st == S_RUN) && s_reg.clk_odd;
   assign active = (int'(s_reg.v_cnt) < V_ACTIVE)
                && (int'(s_reg.h_cnt) < PAIRS);
   assign pop    = launch && active && fifo_valid;

   //=======================================================================
   // Next state
   always_comb begin
      s_next            = s_reg;
      s_next.on_meta    = panel_on_i;
      s_next.on_sync    = s_reg.on_meta;
      s_next.underrun   = 1'b0;
      s_next.frame_done = 1'b0;
      case (s_reg.st)
         S_OFF: begin
            // Panel unpowered: every lane and clock held low
            s_next.clk_odd   = 1'b0;
            s_next.clk_even  = 1'b0;
            s_next.odd_word  = '0;
            s_next.even_word = '0;
            s_next.h_cnt     = '0;
            s_next.v_cnt     = '0;
            if (s_reg.on_sync) begin
               s_next.st = S_RUN;
            end
         end
         S_RUN: begin
            // Fixed divide: zero deviation, zero modulation
            s_next.clk_odd  = ~s_reg.clk_odd;
            s_next.clk_even = ~s_reg.clk_odd;
            if (launch) begin
               if (active) begin
                  // Pair k: odd pixel 2k-1, even pixel 2k
                  if (fifo_valid) begin
                     s_next.odd_word  = dlp_pack(odd_px, 1'b1);
                     s_next.even_word = dlp_pack(even_px, 1'b0);
                  end else begin
                     // Starved: black pair keeps line length intact
                     s_next.odd_word  = dlp_pack('0, 1'b1);
                     s_next.even_word = dlp_pack('0, 1'b0);
                     s_next.underrun  = 1'b1;
                  end
               end else begin
                  s_next.odd_word  = dlp_pack('0, 1'b0);
                  s_next.even_word = dlp_pack('0, 1'b0);
               end
               if (int'(s_reg.h_cnt) == H_TOTAL - 1) begin
                  s_next.h_cnt = '0;
                  if (int'(s_reg.v_cnt) == V_TOTAL - 1) begin
                     s_next.v_cnt      = '0;
                     s_next.frame_done = 1'b1;
                  end else begin
                     s_next.v_cnt = s_reg.v_cnt + 1'b1;
                  end
               end else begin
                  s_next.h_cnt = s_reg.h_cnt + 1'b1;
               end
            end
            // Power loss drops the link at once, mid-frame if need be
            if (!s_reg.on_sync) begin
               s_next.st        = S_OFF;
               s_next.clk_odd   = 1'b0;
               s_next.clk_even  = 1'b0;
               s_next.odd_word  = '0;
               s_next.even_word = '0;
            end
         end
         default: begin
            s_next.st = S_OFF;
         end
      endcase
   end

   //=======================================================================
   // State register
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_reg <= '{on_meta: 1'b0, on_sync: 1'b0, st: S_OFF,
                    clk_odd: 1'b0, clk_even: 1'b0,
                    h_cnt: '0, v_cnt: '0,
                    odd_word: '0, even_word: '0,
                    underrun: 1'b0, frame_done: 1'b0};
      end else begin
         s_reg <= s_next;
      end
   end

   //=======================================================================
   // Lane outputs, four data lanes plus clock per channel
   assign {link.odd_lane_3, link.odd_lane_2,
           link.odd_lane_1, link.odd_lane_0}   = s_reg.odd_word;
   assign {link.even_lane_3, link.even_lane_2,
           link.even_lane_1, link.even_lane_0} = s_reg.even_word;
   assign link.odd_lane_clock  = s_reg.clk_odd;
   assign link.even_lane_clock = s_reg.clk_even;
   assign underrun_o           = s_reg.underrun;
   assign frame_done_o         = s_reg.frame_done;

endmodule : dlp_src

// File: dlp_sink.sv
//==========================================================================
// Purpose: Panel end: captures both channels on the link clock, recovers
//          line and frame position from the display flag alone.
// Assumes: Even clock matches odd clock; only the odd clock is used.
// Notes:   A blank run longer than H_BLANK_MAX marks a new frame.
//==========================================================================
module dlp_sink
   import dlp_pkg::*;
(
   input  wire logic         rst_n_i,
   dlp_link_if.sink          link,
   output logic              pix_valid_o,
   output dlp_rgb_t          pix_odd_o,
   output dlp_rgb_t          pix_even_o,
   output logic [CNT_W-1:0]  pair_idx_o,
   output logic [CNT_W-1:0]  line_o,
   output logic              frame_start_o
);
   typedef struct packed {
      logic             flag_q;
      logic             new_frame;
      logic [CNT_W-1:0] blank_cnt;
      logic [CNT_W-1:0] pair_cnt;
      logic [CNT_W-1:0] line;
      logic             valid;
      dlp_rgb_t         odd;
      dlp_rgb_t         even;
      logic [CNT_W-1:0] idx;
      logic             fstart;
   } dlp_sink_st_t;

   dlp_sink_st_t s_reg;
   dlp_sink_st_t s_next;
   dlp_word_t    odd_word;
   dlp_word_t    even_word;
   logic         flag;

   assign odd_word  = {link.odd_lane_3, link.odd_lane_2,
                       link.odd_lane_1, link.odd_lane_0};
   assign even_word = {link.even_lane_3, link.even_lane_2,
                       link.even_lane_1, link.even_lane_0};
   assign flag      = odd_word[FLAG_BIT];

   //=======================================================================
   // Position tracking; no sync inputs exist, the flag is everything
   always_comb begin
      s_next        = s_reg;
      s_next.flag_q = flag;
      s_next.valid  = 1'b0;
      s_next.fstart = 1'b0;
      if (flag) begin
         s_next.blank_cnt = '0;
         s_next.odd  = dlp_unpack(odd_word);
         s_next.even = dlp_unpack(even_word);
         s_next.valid = 1'b1;
         if (!s_reg.flag_q) begin
            // Rising flag opens a line at pair one
            s_next.idx       = '0;
            s_next.pair_cnt  = CNT_W'(1);
            s_next.new_frame = 1'b0;
            s_next.fstart    = s_reg.new_frame;
            s_next.line      = s_reg.new_frame ? '0
                                               : s_reg.line + 1'b1;
         end else begin
            s_next.idx      = s_reg.pair_cnt;
            s_next.pair_cnt = s_reg.pair_cnt + 1'b1;
         end
      end else begin
         // Blanking: colour lanes are not looked at
         if (int'(s_reg.blank_cnt) < H_BLANK_MAX) begin
            s_next.blank_cnt = s_reg.blank_cnt + 1'b1;
         end else begin
            s_next.new_frame = 1'b1;
         end
         // Last active line closes the frame even on a short gap
         if (s_reg.flag_q && int'(s_reg.line) == V_ACTIVE - 1) begin
            s_next.new_frame = 1'b1;
         end
      end
   end

   // Sample on the rising link edge, mid-way between source launches
   always_ff @(posedge link.odd_lane_clock or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_reg <= '{flag_q: 1'b0, new_frame: 1'b1, blank_cnt: '0,
                    pair_cnt: '0, line: '0, valid: 1'b0,
                    odd: '0, even: '0, idx: '0, fstart: 1'b0};
      end else begin
         s_reg <= s_next;
      end
   end

   assign pix_valid_o   = s_reg.valid;
   assign pix_odd_o     = s_reg.odd;
   assign pix_even_o    = s_reg.even;
   assign pair_idx_o    = s_reg.idx;
   assign line_o        = s_reg.line;
   assign frame_start_o = s_reg.fstart;

endmodule : dlp_sink

// File: dlp_link_asserts.sv
//=====================================================================
// Purpose: Concurrent checks on the two pixel channels between ends.
// Assumes: Link words and clocks are flops of the source's clk_i.
// Notes:   Sampled on clk_i; a link rise is a 0 to 1 step of the clock.
//=====================================================================
module dlp_link_asserts
   import dlp_pkg::*;
(
   input wire logic              clk_i,
   input wire logic              rst_n_i,
   input wire logic [LANE_W-1:0] odd_lane_0,
   input wire logic [LANE_W-1:0] odd_lane_1,
   input wire logic [LANE_W-1:0] odd_lane_2,
   input wire logic [LANE_W-1:0] odd_lane_3,
   input wire logic [LANE_W-1:0] even_lane_0,
   input wire logic [LANE_W-1:0] even_lane_1,
   input wire logic [LANE_W-1:0] even_lane_2,
   input wire logic [LANE_W-1:0] even_lane_3,
   input wire logic              odd_lane_clock,
   input wire logic              even_lane_clock
);
   timeunit 1ns;
   timeprecision 1ps;

   logic                     clk_q;
   logic [CNT_W-1:0]         run_q;
   logic                     rise_w;
   logic                     flag_w;
   logic [8*LANE_W-1:0]      words_w;

   //==================================================================
   // Helpers
   // Link rise seen between two samples; flagged word run length
   assign rise_w  = odd_lane_clock & ~clk_q;
   assign flag_w  = odd_lane_2[LANE_W-1];
   assign words_w = {odd_lane_3, odd_lane_2, odd_lane_1, odd_lane_0,
                     even_lane_3, even_lane_2, even_lane_1, even_lane_0};

   // Counts flagged words at link rises, cleared by a blank word
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         clk_q <= 1'b0;
         run_q <= '0;
      end else begin
         clk_q <= odd_lane_clock;
         if (rise_w) begin
            run_q <= flag_w ? run_q + 1'b1 : '0;
         end
      end
   end

   //==================================================================
   // Assertions
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   clocks_same_a: assert property (
      odd_lane_clock == even_lane_clock)
      else $error("odd and even link clocks differ");
   even_flag_low_a: assert property (
      even_lane_2[LANE_W-1] == 1'b0)
      else $error("flag slot set on even channel");
   spare_bits_low_a: assert property (
      odd_lane_2[5:4] == 2'h0 && even_lane_2[5:4] == 2'h0 &&
      odd_lane_3[LANE_W-1] == 1'b0 && even_lane_3[LANE_W-1] == 1'b0)
      else $error("unused lane slots not zero");
   blank_words_zero_a: assert property (
      !flag_w |-> words_w == '0)
      else $error("colour data sent while blanking");
   launch_on_fall_a: assert property (
      rise_w |-> $stable(words_w))
      else $error("lane words changed at link rise");
   clock_halves_a: assert property (
      odd_lane_clock |=> !odd_lane_clock)
      else $error("link clock high for two clk_i cycles");
   flag_run_max_a: assert property (
      rise_w && flag_w |-> run_q < CNT_W'(PAIRS))
      else $error("more flagged pairs than a line holds");
   flag_run_full_a: assert property (
      rise_w && !flag_w && run_q != '0 |-> run_q == CNT_W'(PAIRS))
      else $error("flagged run shorter than a line");
endmodule : dlp_link_asserts

// File: dual_lvds_pixel_input_tb.sv
//=====================================================================
// Purpose: Source and panel ends joined back to back, checked at both
//          user sides and on the link.
// Assumes: Short horizontal blanking to keep the run brief.
// Notes:   Only the first lines of a frame fit in the run time.
//=====================================================================
module dual_lvds_pixel_input_tb
   import dlp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct packed {
      dlp_rgb_t in_odd;
      dlp_rgb_t in_even;
      dlp_rgb_t exp_odd;
      dlp_rgb_t exp_even;
   } dlp_row_t;

   logic             clk_i       = 1'b0;
   logic             rst_n_i     = 1'b1;
   logic             panel_on_i  = 1'b0;
   logic             pix_valid_i = 1'b0;
   dlp_rgb_t         pix_odd_i   = '0;
   dlp_rgb_t         pix_even_i  = '0;
   logic             pix_ready_o;
   logic             underrun_o;
   logic             frame_done_o;
   logic             snk_valid;
   dlp_rgb_t         snk_odd;
   dlp_rgb_t         snk_even;
   logic [CNT_W-1:0] snk_idx;
   logic [CNT_W-1:0] snk_line;
   logic             snk_fs;
   logic [57:0]      wires;
   logic [47:0]      exp_q[$];
   dlp_row_t         rows[8];
   int               errors, n_compared, k_exp, line_exp;
   int               black_cnt, ur_cnt, fd_cnt;

   //==================================================================
   // Both ends and the link
   always #4 clk_i = ~clk_i;
   dlp_link_if link();
   dlp_src #(.H_BLANK(4), .V_BLANK(2)) dlp_src_i (.clk_i(clk_i),
      .rst_n_i(rst_n_i), .panel_on_i(panel_on_i),
      .pix_valid_i(pix_valid_i), .pix_odd_i(pix_odd_i),
      .pix_even_i(pix_even_i), .pix_ready_o(pix_ready_o),
      .underrun_o(underrun_o), .frame_done_o(frame_done_o), .link(link));
   dlp_sink dlp_sink_i (.rst_n_i(rst_n_i), .link(link),
      .pix_valid_o(snk_valid), .pix_odd_o(snk_odd),
      .pix_even_o(snk_even), .pair_idx_o(snk_idx),
      .line_o(snk_line), .frame_start_o(snk_fs));
   dlp_link_asserts dlp_link_asserts_i (.clk_i(clk_i),
      .rst_n_i(rst_n_i), .odd_lane_0(link.odd_lane_0),
      .odd_lane_1(link.odd_lane_1), .odd_lane_2(link.odd_lane_2),
      .odd_lane_3(link.odd_lane_3), .even_lane_0(link.even_lane_0),
      .even_lane_1(link.even_lane_1), .even_lane_2(link.even_lane_2),
      .even_lane_3(link.even_lane_3),
      .odd_lane_clock(link.odd_lane_clock),
      .even_lane_clock(link.even_lane_clock));
   assign wires = {link.odd_lane_0, link.odd_lane_1, link.odd_lane_2,
      link.odd_lane_3, link.even_lane_0, link.even_lane_1,
      link.even_lane_2, link.even_lane_3, link.odd_lane_clock,
      link.even_lane_clock};

   //==================================================================
   // Tasks
   task automatic check(input logic [63:0] seen, input logic [63:0] exp,
                        input string what);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: %s", $time, what);
      end
   endtask : check

   task automatic tally_and_finish();
      if (errors == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : tally_and_finish

   // Bounded wait of one clock; a hang ends the run as a failure
   task automatic tick(inout int t);
      t++;
      if (t > 20000) begin
         errors++;
         tally_and_finish();
      end else begin
         @(posedge clk_i);
      end
   endtask : tick

   // Holds the pair until the edge that takes it; valid stays up after
   task automatic push(input dlp_rgb_t o, input dlp_rgb_t e,
                       input logic [47:0] x);
      int t;
      t = 0;
      pix_valid_i <= 1'b1;
      pix_odd_i   <= o;
      pix_even_i  <= e;
      tick(t);
      while (pix_ready_o !== 1'b1) begin
         tick(t);
      end
      exp_q.push_back(x);
   endtask : push

   function automatic dlp_rgb_t gen(input int n);
      return {n[7:0], n[15:8], n[7:0] ^ 8'hA5};
   endfunction : gen

   //==================================================================
   // Panel side monitor: outputs settle at the link rise that samples, read at the next fall
   always @(negedge link.odd_lane_clock) begin
      if (rst_n_i === 1'b1 && snk_valid === 1'b1) begin
         if (exp_q.size() > 0) begin
            check({snk_odd, snk_even}, exp_q.pop_front(), "pair");
         end else begin
            check({snk_odd, snk_even}, 48'h0, "black pair");
            black_cnt++;
         end
         check(snk_idx, k_exp, "pair index");
         check(snk_line, line_exp, "line number");
         check(snk_fs, k_exp == 0 && line_exp == 0, "frame start");
         k_exp++;
         if (k_exp == PAIRS) begin
            k_exp = 0;
            line_exp++;
         end
      end
   end

   // Underrun pulses, one per black pair; no frame can end in this run
   always @(posedge clk_i) begin
      if (underrun_o === 1'b1) begin
         ur_cnt++;
      end
      if (frame_done_o === 1'b1) begin
         fd_cnt++;
      end
   end

   //==================================================================
   // Main sequence
   initial begin
      int t;
      // Reset edge at time zero; the panel end has no clock to reset on
      rst_n_i <= 1'b0;
      rows = '{'{24'hFFFFFF, 24'h000000, 24'hFFFFFF, 24'h000000},
               '{24'h800000, 24'h008000, 24'h800000, 24'h008000},
               '{24'h000080, 24'h010101, 24'h000080, 24'h010101},
               '{24'h7F7F7F, 24'hFE0001, 24'h7F7F7F, 24'hFE0001},
               '{24'hAA55AA, 24'h55AA55, 24'hAA55AA, 24'h55AA55},
               '{24'h123456, 24'h654321, 24'h123456, 24'h654321},
               '{24'h0F0F0F, 24'hF0F0F0, 24'h0F0F0F, 24'hF0F0F0},
               '{24'hC3C3C3, 24'h3C3C3C, 24'hC3C3C3, 24'h3C3C3C}};
      repeat (6) @(posedge clk_i);
      rst_n_i <= 1'b1;
      // Supply off: link stays low while the FIFO fills
      foreach (rows[i]) begin
         push(rows[i].in_odd, rows[i].in_even,
              {rows[i].exp_odd, rows[i].exp_even});
      end
      pix_valid_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      check(pix_ready_o, 1'b0, "fifo not full");
      check(wires, 58'h0, "link lines while off");
      // A push into a full FIFO is dropped
      pix_valid_i <= 1'b1;
      pix_odd_i   <= 24'hDEAD00;
      repeat (3) @(posedge clk_i);
      check(pix_ready_o, 1'b0, "refused push");
      // Supply on: stream the rest of two whole lines behind the table rows
      panel_on_i <= 1'b1;
      for (int n = 8; n < 2 * PAIRS; n++) begin
         push(gen(2 * n), gen(2 * n + 1), {gen(2 * n), gen(2 * n + 1)});
      end
      pix_valid_i <= 1'b0;
      // Source then starves: black pairs, line length kept
      t = 0;
      while (exp_q.size() != 0 || black_cnt < 100) begin
         tick(t);
      end
      check(ur_cnt >= black_cnt && ur_cnt <= black_cnt + 2, 1'b1,
            "underrun count");
      check(fd_cnt, 0, "frame end too early");
      // Supply drops mid-line
      panel_on_i <= 1'b0;
      repeat (8) @(posedge clk_i);
      check(wires, 58'h0, "link lines after off");
      // Second reset in mid-run
      rst_n_i <= 1'b0;
      @(posedge clk_i);
      check(pix_ready_o, 1'b1, "ready in reset");
      check(snk_valid, 1'b0, "valid in reset");
      tally_and_finish();
   end
endmodule : dual_lvds_pixel_input_tb
